// ---- pic_ctrl.sv ----
// pic_ctrl: prioritizing interrupt controller with axi4-lite registers and vector fetch
// assumes an axi4-lite master, a cpu that acks the presented request, and a program
// memory that returns pm_data one cycle after pm_rd/pm_addr are sampled
// Contract
// - reset and system exceptions always outrank any maskable request
// - vector entry is two bytes, high at even address, low at odd
// - reset, watchdog and illegal trap vector at 0002h, 0004h, 0006h
// - primary oscillator fail at 003AH, watchdog oscillator fail at 003CH
// - maskable sources from 0008h in steps of two, fixed descending order
// - port C0 at 001CH, port B low nibble at 001EH on both edges
// - four port A pair sources at 0020h to 0026H, reserved range lowest
// - pair select 0 routes lower pin, 1 routes upper pin
// - per-pin edge select 0 falling, 1 rising
// - global enable clear blocks every maskable request
// - enable set by enable, return instruction or writing 1
// - enable cleared by disable, ack, write 0, reset, trap, illegal trap
// - system exceptions except watchdog ignore the global enable
// - level 3 beats 2 beats 1, fixed order within a level
// - request sets pending bit, vectoring clears it
// - writing 0 to a pending bit clears only that bit
// - writing 1 to a pending bit raises it like hardware
//
// Our own choices: the address map and the AXI4-Lite register port.
module pic_ctrl
  import pic_pkg::*;
(
  input  wire logic                clk,
  input  wire logic                reset,
  input  wire logic [AXI_AW-1:0]   s_axi_awaddr,
  input  wire logic                s_axi_awvalid,
  output logic                     s_axi_awready,
  input  wire logic [31:0]         s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  input  wire logic                s_axi_wvalid,
  output logic                     s_axi_wready,
  output logic [1:0]               s_axi_bresp,
  output logic                     s_axi_bvalid,
  input  wire logic                s_axi_bready,
  input  wire logic [AXI_AW-1:0]   s_axi_araddr,
  input  wire logic                s_axi_arvalid,
  output logic                     s_axi_arready,
  output logic [31:0]              s_axi_rdata,
  output logic [1:0]               s_axi_rresp,
  output logic                     s_axi_rvalid,
  input  wire logic                s_axi_rready,
  input  wire logic                cpu_ack,
  input  wire logic                enable_irq_instruction,
  input  wire logic                disable_irq_instruction,
  input  wire logic                return_from_service_instruction,
  input  wire logic                trap_instruction,
  input  wire logic [NPERIPH-1:0]  periph_irq,
  input  wire logic                watchdog_event,
  input  wire logic                illegal_instr_trap,
  input  wire logic                primary_osc_fail,
  input  wire logic                watchdog_osc_fail,
  input  wire logic [7:0]          port_a,
  input  wire logic [3:0]          port_b,
  input  wire logic                port_c0,
  output logic                     irq_request,
  output logic [15:0]              irq_vector,
  output logic [4:0]               irq_source_id,
  output logic                     pm_rd,
  output logic [15:0]              pm_addr,
  input  wire logic [7:0]          pm_data,
  output logic                     handler_valid,
  output logic [15:0]              handler_addr
);

  typedef struct packed {
    logic              awready;
    logic              wready;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              arready;
    logic              rvalid;
    logic [31:0]       rdata;
    logic [1:0]        rresp;
    logic              aw_full;
    logic [AXI_AW-1:0] aw_addr;
    logic              w_full;
    logic [31:0]       w_data;
    logic [3:0]        w_strb;
    logic              en;
    logic [NSRC-1:0]   pend;
    logic [2*NSRC-1:0] prio;
    logic [NPAIR-1:0]  pair_sel;
    logic [7:0]        edge_sel;
    logic              c0_edge;
    logic [NEXC-1:0]   exc;
    logic              req;
    logic [4:0]        id;
    logic [15:0]       vec;
    pic_fetch_t        fstate;
    logic              pm_rd;
    logic [15:0]       pm_addr;
    logic [7:0]        hi;
    logic              hv;
    logic [15:0]       haddr;
  } pic_st_t;

  pic_st_t          st_reg;
  pic_st_t          st_next;
  logic [EDGE_W-1:0] rise;
  logic [EDGE_W-1:0] fall;
  logic [NSRC-1:0]  hw_set;
  logic [NSRC-1:0]  pend_sw;
  logic [NSRC-1:0]  ack_mask;
  logic [NEXC-1:0]  exc_clr;
  logic [NEXC-1:0]  exc_live;
  logic [31:0]      wmerge;
  logic [2:0]       pa_pin;
  logic [4:0]       exc_idx;
  logic             do_write;
  logic             do_ack;
  logic             en_wr1;
  logic             en_wr0;

  // port pins: a[7:0], b[3:0], c0
  pic_edge u_edge (
    .clk   (clk),
    .reset (reset),
    .pins  ({port_c0, port_b, port_a}),
    .rise  (rise),
    .fall  (fall)
  );

  // next state: bus slave, request bits, enable, resolver, vector fetch
  always_comb begin
    st_next  = st_reg;
    hw_set   = '0;
    ack_mask = '0;
    exc_clr  = '0;
    wmerge   = '0;
    pa_pin   = '0;
    exc_idx  = '0;
    en_wr1   = 1'b0;
    en_wr0   = 1'b0;
    st_next.hv = 1'b0;

    // hardware request sources
    hw_set[NPERIPH-1:0] = periph_irq;
    // port c0 edge select, port b any edge
    hw_set[SRC_PORT_C0] = st_reg.c0_edge ? rise[EDGE_C0] : fall[EDGE_C0];
    hw_set[SRC_PORT_B]  = |(rise[EDGE_PB_LSB +: 4] | fall[EDGE_PB_LSB +: 4]);
    for (int k = 0; k < NPAIR; k++) begin
      // pair routing 7/3 down to 4/0
      pa_pin = st_reg.pair_sel[3-k] ? 3'(7-k) : 3'(3-k);
      hw_set[SRC_PORT_A0+k] = st_reg.edge_sel[pa_pin] ? rise[EDGE_PA_LSB+pa_pin] : fall[EDGE_PA_LSB+pa_pin];
    end

    // write channels taken independently, answered when both are held
    if (st_reg.awready && s_axi_awvalid) begin
      st_next.aw_full = 1'b1;
      st_next.aw_addr = s_axi_awaddr;
    end
    if (st_reg.wready && s_axi_wvalid) begin
      st_next.w_full = 1'b1;
      st_next.w_data = s_axi_wdata;
      st_next.w_strb = s_axi_wstrb;
    end
    do_write = st_reg.aw_full && st_reg.w_full && !st_reg.bvalid;
    pend_sw  = st_reg.pend;
    if (do_write) begin
      st_next.aw_full = 1'b0;
      st_next.w_full  = 1'b0;
      st_next.bvalid  = 1'b1;
      st_next.bresp   = RESP_OKAY;
      case (st_reg.aw_addr)
        OFF_CTRL: begin
          en_wr1 = st_reg.w_strb[0] && st_reg.w_data[CTRL_EN_BIT];
          en_wr0 = st_reg.w_strb[0] && !st_reg.w_data[CTRL_EN_BIT];
        end
        OFF_PEND: begin
          // plain store of 0 clears, 1 raises
          wmerge  = pic_merge({16'h0000, st_reg.pend}, st_reg.w_data, st_reg.w_strb);
          pend_sw = wmerge[NSRC-1:0];
        end
        OFF_PEND_OR: begin
          // atomic set, untouched lanes act as zero
          wmerge  = pic_merge('0, st_reg.w_data, st_reg.w_strb);
          pend_sw = st_reg.pend | wmerge[NSRC-1:0];
        end
        OFF_PEND_AND: begin
          // atomic clear, untouched lanes act as ones
          wmerge  = pic_merge('1, st_reg.w_data, st_reg.w_strb);
          pend_sw = st_reg.pend & wmerge[NSRC-1:0];
        end
        OFF_PRIO: begin
          st_next.prio = pic_merge(st_reg.prio, st_reg.w_data, st_reg.w_strb);
        end
        OFF_PORT: begin
          wmerge = pic_merge({19'h00000, st_reg.c0_edge, st_reg.edge_sel, st_reg.pair_sel},
                             st_reg.w_data, st_reg.w_strb);
          st_next.pair_sel = wmerge[PORT_SEL_LSB +: NPAIR];
          st_next.edge_sel = wmerge[PORT_EDGE_LSB +: 8];
          st_next.c0_edge  = wmerge[PORT_C0_BIT];
        end
        OFF_STATUS: begin
        end
        default: begin
          st_next.bresp = RESP_SLVERR;
        end
      endcase
    end
    if (st_reg.bvalid && s_axi_bready) begin
      st_next.bvalid = 1'b0;
    end
    // no new write is taken while a response is pending
    st_next.awready = !st_next.aw_full && !st_next.bvalid;
    st_next.wready  = !st_next.w_full && !st_next.bvalid;

    // read channel, one outstanding read
    if (st_reg.arready && s_axi_arvalid) begin
      st_next.rvalid = 1'b1;
      st_next.rresp  = RESP_OKAY;
      st_next.rdata  = '0;
      case (s_axi_araddr)
        OFF_CTRL:     st_next.rdata[CTRL_EN_BIT] = st_reg.en;
        OFF_PEND,
        OFF_PEND_OR,
        OFF_PEND_AND: st_next.rdata[NSRC-1:0] = st_reg.pend;
        OFF_PRIO:     st_next.rdata = st_reg.prio;
        OFF_PORT:     st_next.rdata[PORT_C0_BIT:0] = {st_reg.c0_edge, st_reg.edge_sel, st_reg.pair_sel};
        OFF_STATUS: begin
          st_next.rdata[STAT_VEC_LSB +: 16]  = st_reg.vec;
          st_next.rdata[STAT_ID_LSB +: 5]    = st_reg.id;
          st_next.rdata[STAT_REQ_BIT]        = st_reg.req;
          st_next.rdata[STAT_EXC_LSB +: NEXC] = st_reg.exc;
        end
        default:      st_next.rresp = RESP_SLVERR;
      endcase
    end
    if (st_reg.rvalid && s_axi_rready) begin
      st_next.rvalid = 1'b0;
    end
    st_next.arready = !st_next.rvalid;

    // ack of the presented source clears its bit and starts the fetch
    do_ack = cpu_ack && st_reg.req && (st_reg.fstate == FETCH_IDLE);
    if (do_ack) begin
      if (st_reg.id >= ID_EXC_BASE) begin
        exc_idx = st_reg.id - ID_EXC_BASE;
        exc_clr[exc_idx[2:0]] = 1'b1;
      end else begin
        ack_mask[st_reg.id[3:0]] = 1'b1;
      end
      st_next.fstate  = FETCH_HI;
      st_next.pm_rd   = 1'b1;
      st_next.pm_addr = st_reg.vec;
    end
    // hardware set wins over software and ack clears
    st_next.pend = (pend_sw & ~ack_mask) | hw_set;
    st_next.exc  = (st_reg.exc & ~exc_clr) |
                   {illegal_instr_trap, watchdog_osc_fail, primary_osc_fail, watchdog_event, 1'b0};

    // clearing events win over setting events
    st_next.en = (st_reg.en | enable_irq_instruction | return_from_service_instruction | en_wr1) &
                 ~(disable_irq_instruction | do_ack | en_wr0 | trap_instruction | illegal_instr_trap);

    // resolve on the post-update state so the presentation never shows a served source
    st_next.req = 1'b0;
    st_next.id  = '0;
    // level ascending, index descending: last match is the winner
    for (int lvl = 1; lvl <= LVL_MAX; lvl++) begin
      for (int i = NSRC - 1; i >= 0; i--) begin
        if (st_next.en && st_next.pend[i] && st_next.prio[2*i +: 2] == 2'(lvl)) begin
          st_next.req = 1'b1;
          st_next.id  = 5'(i);
        end
      end
    end
    // only the watchdog exception honours the enable
    exc_live = st_next.exc;
    exc_live[EXC_WDT] = st_next.exc[EXC_WDT] && st_next.en;
    for (int e = NEXC - 1; e >= 0; e--) begin
      if (exc_live[e]) begin
        st_next.req = 1'b1;
        st_next.id  = ID_EXC_BASE + 5'(e);
      end
    end
    st_next.vec = st_next.req ? pic_vec_of(st_next.id) : '0;

    // fetch high byte at even address, then low byte at odd
    case (st_reg.fstate)
      FETCH_IDLE: begin
      end
      FETCH_HI: begin
        st_next.pm_addr = st_reg.pm_addr | VEC_ODD;
        st_next.fstate  = FETCH_LO;
      end
      FETCH_LO: begin
        st_next.hi     = pm_data;
        st_next.pm_rd  = 1'b0;
        st_next.fstate = FETCH_DONE;
      end
      FETCH_DONE: begin
        st_next.hv     = 1'b1;
        st_next.haddr  = {st_reg.hi, pm_data};
        st_next.fstate = FETCH_IDLE;
      end
      default: st_next.fstate = FETCH_IDLE;
    endcase
  end

  // reset clears the enable and leaves only the reset exception pending
  always_ff @(posedge clk) begin
    if (reset) begin
      st_reg     <= '0;
      st_reg.exc <= EXC_INIT;
    end else begin
      st_reg <= st_next;
    end
  end

  // outputs straight from the state register
  assign s_axi_awready = st_reg.awready;
  assign s_axi_wready  = st_reg.wready;
  assign s_axi_bvalid  = st_reg.bvalid;
  assign s_axi_bresp   = st_reg.bresp;
  assign s_axi_arready = st_reg.arready;
  assign s_axi_rvalid  = st_reg.rvalid;
  assign s_axi_rdata   = st_reg.rdata;
  assign s_axi_rresp   = st_reg.rresp;
  assign irq_request   = st_reg.req;
  assign irq_vector    = st_reg.vec;
  assign irq_source_id = st_reg.id;
  assign pm_rd         = st_reg.pm_rd;
  assign pm_addr       = st_reg.pm_addr;
  assign handler_valid = st_reg.hv;
  assign handler_addr  = st_reg.haddr;

  // checks on the pending bits, the enable, the presented request and the fetch
  // the presentation registers only catch up one edge after reset release
  a_exc_over_mask: assert property (@(posedge clk) disable iff (reset)
    (!$past(reset) && (st_reg.exc & ~(NEXC'(!st_reg.en) << EXC_WDT)) != '0)
      |-> (irq_request && irq_source_id >= ID_EXC_BASE))
    else $error("maskable source shown over a pending exception");
  a_vec_byte_order: assert property (@(posedge clk) disable iff (reset)
    handler_valid |-> handler_addr == {$past(pm_data, 2), $past(pm_data)})
    else $error("handler address bytes out of order");
  a_fixed_exc_vec: assert property (@(posedge clk) disable iff (reset)
    (irq_request && irq_source_id == ID_RESET) |-> irq_vector == VEC_RESET)
    else $error("reset vector wrong");
  a_osc_fail_vec: assert property (@(posedge clk) disable iff (reset)
    (irq_request && irq_source_id == ID_POSC) |-> irq_vector == VEC_POSC)
    else $error("oscillator fail vector wrong");
  a_mask_vec_step: assert property (@(posedge clk) disable iff (reset)
    (irq_request && irq_source_id < ID_EXC_BASE) |-> irq_vector == VEC_MASK_BASE + {10'h000, irq_source_id, 1'b0})
    else $error("maskable vector wrong");
  a_port_b_edge: assert property (@(posedge clk) disable iff (reset)
    (port_b != $past(port_b)) |=> st_reg.pend[SRC_PORT_B])
    else $error("port b edge not recorded");
  a_pair_rise_sel: assert property (@(posedge clk) disable iff (reset)
    (!st_reg.pair_sel[0] && st_reg.edge_sel[0] && port_a[0] && !$past(port_a[0])) |=> st_reg.pend[SRC_PORT_A0+3])
    else $error("port a rising edge lost");
  a_global_gate: assert property (@(posedge clk) disable iff (reset)
    (irq_request && irq_source_id < ID_EXC_BASE) |-> st_reg.en)
    else $error("maskable request shown while disabled");
  a_enable_set: assert property (@(posedge clk) disable iff (reset)
    (enable_irq_instruction && !disable_irq_instruction && !trap_instruction && !illegal_instr_trap && !cpu_ack)
      && !en_wr0 |=> st_reg.en)
    else $error("enable instruction did not set enable");
  a_ack_disables: assert property (@(posedge clk) disable iff (reset)
    (cpu_ack && irq_request && st_reg.fstate == FETCH_IDLE) |=> (!st_reg.en ##1 pm_rd ##1 !pm_rd))
    else $error("ack did not disable or fetch");
  a_nmi_no_gate: assert property (@(posedge clk) disable iff (reset)
    primary_osc_fail |=> irq_request && irq_source_id >= ID_EXC_BASE)
    else $error("oscillator fail not presented");
  a_request_sets: assert property (@(posedge clk) disable iff (reset)
    periph_irq[0] |=> st_reg.pend[0])
    else $error("peripheral request lost");

  c_mask_served: cover property (@(posedge clk) disable iff (reset)
    cpu_ack && irq_request && irq_source_id < ID_EXC_BASE ##4 handler_valid);
  c_exc_served: cover property (@(posedge clk) disable iff (reset)
    cpu_ack && irq_request && irq_source_id == ID_ILL);
  c_level_three: cover property (@(posedge clk) disable iff (reset)
    irq_request && irq_source_id < ID_EXC_BASE && st_reg.prio[2*irq_source_id[3:0] +: 2] == 2'(LVL_MAX));

endmodule : pic_ctrl

// ---- pic_pkg.sv ----
// pic_pkg: constants, register map, vector table and helpers of the interrupt controller
// assumes a 32-bit axi4-lite master and an 8-bit program memory with one cycle read latency
package pic_pkg;

  // register byte offsets on the axi4-lite bus
  localparam int          AXI_AW        = 8;
  localparam logic [7:0]  OFF_CTRL      = 8'h00;
  localparam logic [7:0]  OFF_PEND      = 8'h04;
  localparam logic [7:0]  OFF_PEND_OR   = 8'h08;
  localparam logic [7:0]  OFF_PEND_AND  = 8'h0c;
  localparam logic [7:0]  OFF_PRIO      = 8'h10;
  localparam logic [7:0]  OFF_PORT      = 8'h14;
  localparam logic [7:0]  OFF_STATUS    = 8'h18;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;

  // field layout
  localparam int          CTRL_EN_BIT   = 0;
  localparam int          PORT_SEL_LSB  = 0;
  localparam int          PORT_EDGE_LSB = 4;
  localparam int          PORT_C0_BIT   = 12;
  localparam int          STAT_VEC_LSB  = 0;
  localparam int          STAT_ID_LSB   = 16;
  localparam int          STAT_REQ_BIT  = 24;
  localparam int          STAT_EXC_LSB  = 25;

  // maskable sources, index order is fixed priority within a level (0 highest)
  localparam int          NSRC          = 16;
  localparam int          NPERIPH       = 9;
  localparam int          SRC_PORT_C0   = 10;
  localparam int          SRC_PORT_B    = 11;
  localparam int          SRC_PORT_A0   = 12;
  localparam int          NPAIR         = 4;
  localparam logic [1:0]  LVL_OFF       = 2'h0;
  localparam int          LVL_MAX       = 3;

  // system exceptions, bit order is fixed priority (0 highest)
  localparam int          NEXC          = 5;
  localparam int          EXC_RESET     = 0;
  localparam int          EXC_WDT       = 1;
  localparam int          EXC_POSC      = 2;
  localparam int          EXC_WOSC      = 3;
  localparam int          EXC_ILL       = 4;
  localparam logic [4:0]  EXC_INIT      = 5'h01;
  localparam logic [4:0]  ID_EXC_BASE   = 5'h10;
  localparam logic [4:0]  ID_RESET      = 5'h10;
  localparam logic [4:0]  ID_WDT        = 5'h11;
  localparam logic [4:0]  ID_POSC       = 5'h12;
  localparam logic [4:0]  ID_WOSC       = 5'h13;
  localparam logic [4:0]  ID_ILL        = 5'h14;

  // vector base addresses
  localparam logic [15:0] VEC_RESET     = 16'h0002;
  localparam logic [15:0] VEC_WDT       = 16'h0004;
  localparam logic [15:0] VEC_ILL       = 16'h0006;
  localparam logic [15:0] VEC_POSC      = 16'h003a;
  localparam logic [15:0] VEC_WOSC      = 16'h003c;
  localparam logic [15:0] VEC_MASK_BASE = 16'h0008;
  localparam logic [15:0] VEC_ODD       = 16'h0001;

  // pin edge detector lanes
  localparam int          EDGE_W        = 13;
  localparam int          EDGE_PA_LSB   = 0;
  localparam int          EDGE_PB_LSB   = 8;
  localparam int          EDGE_C0       = 12;

  typedef enum logic [1:0] {FETCH_IDLE, FETCH_HI, FETCH_LO, FETCH_DONE} pic_fetch_t;

  // vector of a source id; maskable vectors step by two bytes
  function automatic logic [15:0] pic_vec_of(input logic [4:0] id);
    case (id)
      ID_RESET: pic_vec_of = VEC_RESET;
      ID_WDT:   pic_vec_of = VEC_WDT;
      ID_POSC:  pic_vec_of = VEC_POSC;
      ID_WOSC:  pic_vec_of = VEC_WOSC;
      ID_ILL:   pic_vec_of = VEC_ILL;
      default:  pic_vec_of = VEC_MASK_BASE + {11'h000, id[3:0], 1'b0};
    endcase
  endfunction : pic_vec_of

  // byte-lane merge of write data under wstrb
  function automatic logic [31:0] pic_merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] strb);
    pic_merge = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        pic_merge[8*b +: 8] = wd[8*b +: 8];
      end
    end
  endfunction : pic_merge

endpackage : pic_pkg

// ---- pic_edge.sv ----
// pic_edge: rise and fall detection on the port pins
// assumes pins are synchronous to clk; first cycle after reset reports no edge
module pic_edge
  import pic_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              reset,
  input  wire logic [EDGE_W-1:0] pins,
  output logic      [EDGE_W-1:0] rise,
  output logic      [EDGE_W-1:0] fall
);

  typedef struct packed {
    logic [EDGE_W-1:0] prev;
  } pic_edge_st_t;

  pic_edge_st_t edge_reg;
  pic_edge_st_t edge_next;

  // previous sample; reset loads the pins so no false edge after release
  always_comb begin
    edge_next      = edge_reg;
    edge_next.prev = pins;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      edge_reg.prev <= pins;
    end else begin
      edge_reg <= edge_next;
    end
  end

  // edges against the stored sample
  assign rise = pins & ~edge_reg.prev;
  assign fall = ~pins & edge_reg.prev;

endmodule : pic_edge

// ---- pic_cpu_model.sv ----
// pic_cpu_model: cpu core and program memory beside the interrupt controller
// assumes pm_rd/pm_addr are sampled at clk and data is due one cycle later
module pic_cpu_model #(
  parameter int ACK_WAIT = 2
) (
  input  wire logic        clk,
  input  wire logic        go,
  input  wire logic        irq_request,
  input  wire logic        pm_rd,
  input  wire logic [15:0] pm_addr,
  output logic             cpu_ack = 1'b0,
  output logic [7:0]       pm_data = 8'h00
);
  timeunit 1ns;
  timeprecision 1ps;
  int   cnt  = 0;
  logic busy = 1'b0;
  // one ack per go; a slow core lets the request stand first
  always @(posedge clk) begin
    cpu_ack <= 1'b0;
    if (!go) begin
      busy <= 1'b0;
      cnt  <= 0;
    end else if (irq_request && !busy) begin
      cnt <= cnt + 1;
      if (cnt == ACK_WAIT) begin
        cpu_ack <= 1'b1;
        busy    <= 1'b1;
      end
    end
  end
  // one byte per address
  // an idle bus toggles, so stale data never passes for a match
  always @(posedge clk) begin
    pm_data <= pm_rd ? (pm_addr[7:0] ^ 8'h3c) : ~pm_data;
  end
endmodule : pic_cpu_model

// ---- pic_ctrl_tb.sv ----
// pic_ctrl_tb: self-checking bench of the interrupt controller
// assumes the package register offsets and a core model that acks while go is high
module pic_ctrl_tb import pic_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0, reset = 1'b1, go = 1'b0, port_c0 = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, ev = 8'h00, port_a = 8'h00, pm_data;
  logic [31:0] s_axi_wdata = 32'h0, d, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'hf, port_b = 4'h0;
  logic [8:0]  periph_irq = 9'h000;
  logic [1:0]  r, s_axi_bresp, s_axi_rresp;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, cpu_ack;
  logic        irq_request, pm_rd, handler_valid;
  logic [15:0] irq_vector, pm_addr, handler_addr;
  logic [4:0]  irq_source_id;
  int          fails = 0, tests_run = 0, cyc = 0;
  logic [15:0] rows [16] = '{16'h0008, 16'h000a, 16'h000c, 16'h000e, 16'h0010, 16'h0012, 16'h0014, 16'h0016,
                             16'h0018, 16'h001a, 16'h001c, 16'h001e, 16'h0020, 16'h0022, 16'h0024, 16'h0026};
  pic_ctrl pic_ctrl_inst (
    .clk, .reset, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .cpu_ack, .enable_irq_instruction(ev[0]),
    .disable_irq_instruction(ev[1]), .return_from_service_instruction(ev[2]), .trap_instruction(ev[3]),
    .periph_irq, .watchdog_event(ev[4]), .illegal_instr_trap(ev[5]), .primary_osc_fail(ev[6]),
    .watchdog_osc_fail(ev[7]), .port_a, .port_b, .port_c0, .irq_request, .irq_vector, .irq_source_id,
    .pm_rd, .pm_addr, .pm_data, .handler_valid, .handler_addr);
  pic_cpu_model pic_cpu_model_inst (.clk, .go, .irq_request, .pm_rd, .pm_addr, .cpu_ack, .pm_data);
  task automatic complete_run;
    if (fails == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : complete_run
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask : tick
  task automatic fire(input logic [7:0] m);
    ev <= m;
    @(posedge clk);
    ev <= 8'h00;
  endtask : fire
  // address and data offered together, each released once taken
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] v);
    logic ta, tw;
    ta = 1'b0;
    tw = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(ta && tw)) begin
      @(posedge clk);
      if (!ta && s_axi_awready) begin
        ta = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!tw && s_axi_wready) begin
        tw = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge clk); while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : axi_wr
  task automatic axi_rd(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge clk); while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : axi_rd
  // one service: ack, two-byte fetch, handler address
  task automatic svc(input logic [15:0] v);
    go <= 1'b1;
    do @(posedge clk); while (!handler_valid);
    chk(handler_addr, {v[7:0] ^ 8'h3c, (v[7:0] | 8'h01) ^ 8'h3c});
    go <= 1'b0;
    @(posedge clk);
  endtask : svc
  initial begin
    forever #4 clk = ~clk;
  end
  // ceiling well above the several hundred cycles the sequence needs
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails++;
      complete_run();
    end
  end
  initial begin
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    tick(2);
    chk(irq_vector, 16'h0002);
    chk(irq_source_id, 5'h10);
    svc(16'h0002);
    axi_wr(OFF_PRIO, 32'h5555_5555);
    // atomic set through the or alias
    for (int i = 0; i < 16; i++) begin
      axi_wr(OFF_CTRL, 32'h1);
      axi_wr(OFF_PEND_OR, 32'h1 << i);
      tick(2);
      chk(irq_vector, rows[i]);
      svc(rows[i]);
      axi_rd(OFF_PEND);
      chk(d, 32'h0);
      axi_rd(OFF_CTRL);
      chk(d[0], 1'b0);
    end
    axi_wr(OFF_PRIO, 32'hc000_0001);
    axi_wr(OFF_CTRL, 32'h1);
    axi_wr(OFF_PEND_OR, 32'h8001);
    tick(2);
    chk(irq_vector, 16'h0026);
    fire(8'h02);
    tick(2);
    chk(irq_request, 1'b0);
    fire(8'h01);
    tick(2);
    chk(irq_request, 1'b1);
    fire(8'h08);
    tick(2);
    chk(irq_request, 1'b0);
    fire(8'h04);
    tick(2);
    chk(irq_vector, 16'h0026);
    fire(8'h40);
    tick(2);
    chk(irq_vector, 16'h003a);
    svc(16'h003a);
    fire(8'hb0);
    tick(2);
    chk(irq_vector, 16'h003c);
    svc(16'h003c);
    chk(irq_vector, 16'h0006);
    svc(16'h0006);
    tick(2);
    chk(irq_request, 1'b0);
    fire(8'h01);
    tick(2);
    chk(irq_vector, 16'h0004);
    svc(16'h0004);
    // hardware pulse lands on the very edge the atomic clear takes effect
    fork
      axi_wr(OFF_PEND_AND, 32'hffff_7ffe);
      begin
        @(posedge clk);
        periph_irq <= 9'h001;
        @(posedge clk);
        periph_irq <= 9'h000;
      end
    join
    axi_rd(OFF_PEND);
    chk(d, 32'h1);
    axi_wr(OFF_PEND_OR, 32'h6);
    axi_wr(OFF_PEND_AND, 32'hffff_fffd);
    axi_rd(OFF_PEND);
    chk(d, 32'h5);
    axi_wr(OFF_PEND, 32'h0);
    axi_wr(OFF_PORT, 32'h1888);
    port_a <= 8'h08;
    tick(3);
    axi_rd(OFF_PEND);
    chk(d, 32'h0);
    port_a <= 8'h88;
    port_b <= 4'h1;
    port_c0 <= 1'b1;
    tick(3);
    axi_rd(OFF_PEND);
    chk(d, 32'h1c00);
    axi_wr(OFF_PEND, 32'h0);
    port_a <= 8'h08;
    port_b <= 4'h0;
    tick(3);
    axi_rd(OFF_PEND);
    chk(d, 32'h0800);
    axi_wr(8'h1c, 32'h1);
    chk(r, RESP_SLVERR);
    axi_rd(8'h20);
    chk(r, RESP_SLVERR);
    axi_wr(OFF_PORT, 32'h0010);
    axi_wr(OFF_PEND, 32'h0);
    port_a <= 8'h01;
    port_c0 <= 1'b0;
    tick(3);
    axi_rd(OFF_PEND);
    chk(d, 32'h9400);
    axi_wr(OFF_CTRL, 32'h1);
    axi_rd(OFF_STATUS);
    chk(d, 32'h010f_0026);
    axi_wr(OFF_CTRL, 32'h0);
    chk(irq_request, 1'b0);
    axi_wr(OFF_CTRL, 32'h1);
    reset <= 1'b1;
    tick(2);
    reset <= 1'b0;
    tick(2);
    chk(irq_vector, 16'h0002);
    chk(irq_source_id, 5'h10);
    axi_rd(OFF_CTRL);
    chk(d, 32'h0);
    complete_run();
  end
endmodule : pic_ctrl_tb
